// ### sfi_regs.vh
// Constants for the serial frame input block
`ifndef SFI_REGS_VH
`define SFI_REGS_VH
`define SFI_WORD_BITS    16
`define SFI_CNT_BITS     6
`define SFI_CNT_FULL     6'h10
`define SFI_CNT_ABORT    6'h0f
`define SFI_CNT_MAX      6'h3f
`define SFI_WORD_RST     16'h0000
`define SFI_SCLK_IDLE    3'h7
`define SFI_SYNC_IDLE    3'h7
`define SFI_DIN_RST      2'h0
`endif

// ### sfi_buf2.v
// Two-entry valid/ready buffer for received words
`timescale 1ns/1ps
module sfi_buf2 #(
  parameter WIDTH = 16
) (
  input  wire             clk_i,
  input  wire             rst_n_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_q [0:1];
  reg             wr_q;
  reg             rd_q;
  reg [1:0]       cnt_q;
  wire            push;
  wire            pop;

  assign in_ready_o  = (cnt_q != 2'h2);
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      cnt_q    <= 2'h0;
      mem_q[0] <= {WIDTH{1'b0}};
      mem_q[1] <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data_i;
        wr_q        <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      case ({push, pop})
        2'b10:   cnt_q <= cnt_q + 2'h1;
        2'b01:   cnt_q <= cnt_q - 2'h1;
        default: cnt_q <= cnt_q;
      endcase
    end
  end
endmodule // sfi_buf2

// ### sfi_frame_rx.v
// Serial frame input port: shift register, frame update, abort and chain output
// Operation
// - Shift data in on clock falls while framed
// - Strobe rise after 16 falls applies word
// - Rise before 16th fall aborts, nothing changes
// - Chain output driven only past 16 clocks
`timescale 1ns/1ps
`include "sfi_regs.vh"
module sfi_frame_rx #(
  parameter WIDTH = `SFI_WORD_BITS
) (
  input  wire             clk_i,
  input  wire             rst_n_i,
  input  wire             sclk_i,
  input  wire             sync_n_i,
  input  wire             sdin_i,
  output reg              sdout_o,
  output reg              sdout_oe_o,
  output reg  [WIDTH-1:0] word_o,
  output reg              word_valid_o,
  input  wire             word_ready_i,
  output reg              overflow_o
);
  // ---------------------------------------------------------------
  // Local constants
  // ---------------------------------------------------------------
  localparam CNT_W = `SFI_CNT_BITS;

  // Frame phases, tracked from the strobe fall to its rise
  localparam [1:0] PH_IDLE  = 2'h0;
  localparam [1:0] PH_SHIFT = 2'h1;
  localparam [1:0] PH_FULL  = 2'h2;
  localparam [1:0] PH_CHAIN = 2'h3;

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Falling edge between an older and a newer synchronised sample
  function edge_fall;
    input old_bit;
    input new_bit;
    begin
      edge_fall = old_bit & ~new_bit;
    end
  endfunction

  // Rising edge between an older and a newer synchronised sample
  function edge_rise;
    input old_bit;
    input new_bit;
    begin
      edge_rise = ~old_bit & new_bit;
    end
  endfunction

  // Edge counter step that holds at the top instead of wrapping
  function [CNT_W-1:0] sat_inc;
    input [CNT_W-1:0] val;
    begin
      if (val == `SFI_CNT_MAX) begin
        sat_inc = val;
      end else begin
        sat_inc = val + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Idle levels are loaded at reset so no false edge follows release
  reg [2:0] sclk_q;
  reg [2:0] sync_q;
  reg [1:0] din_q;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_q <= `SFI_SCLK_IDLE;
      sync_q <= `SFI_SYNC_IDLE;
      din_q  <= `SFI_DIN_RST;
    end else begin
      sclk_q <= {sclk_q[1:0], sclk_i};
      sync_q <= {sync_q[1:0], sync_n_i};
      din_q  <= {din_q[0], sdin_i};
    end
  end

  // Only the second and third stages feed logic
  wire sclk_fall = edge_fall(sclk_q[2], sclk_q[1]);
  wire sync_fall = edge_fall(sync_q[2], sync_q[1]);
  wire sync_rise = edge_rise(sync_q[2], sync_q[1]);
  wire framed    = ~sync_q[2];
  wire shift_en  = framed & sclk_fall;

  // ---------------------------------------------------------------
  // Edge counter
  // ---------------------------------------------------------------
  reg [CNT_W-1:0] cnt_q;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= {CNT_W{1'b0}};
    end else if (sync_fall) begin
      cnt_q <= {CNT_W{1'b0}};
    end else if (shift_en) begin
      cnt_q <= sat_inc(cnt_q);
    end
  end

  // ---------------------------------------------------------------
  // Input shift register and chain bit
  // ---------------------------------------------------------------
  // The bit leaving the top is the data seen 16 falls earlier
  reg [WIDTH-1:0] shift_q;
  reg             out_bit_q;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_q   <= `SFI_WORD_RST;
      out_bit_q <= 1'b0;
    end else if (shift_en) begin
      shift_q   <= {shift_q[WIDTH-2:0], din_q[1]};
      out_bit_q <= shift_q[WIDTH-1];
    end
  end

  // ---------------------------------------------------------------
  // Frame phase
  // ---------------------------------------------------------------
  // FULL is reached on the 16th fall, CHAIN on any fall after it
  reg [1:0] phase_q;
  reg [1:0] phase_d;

  always @* begin
    phase_d = phase_q;
    case (phase_q)
      PH_IDLE: begin
        if (sync_fall) begin
          phase_d = PH_SHIFT;
        end
      end
      PH_SHIFT: begin
        if (sync_rise) begin
          phase_d = PH_IDLE;
        end else if (shift_en && (cnt_q == `SFI_CNT_ABORT)) begin
          phase_d = PH_FULL;
        end
      end
      PH_FULL: begin
        if (sync_rise) begin
          phase_d = PH_IDLE;
        end else if (shift_en && (cnt_q == `SFI_CNT_FULL)) begin
          phase_d = PH_CHAIN;
        end
      end
      PH_CHAIN: begin
        if (sync_rise) begin
          phase_d = PH_IDLE;
        end
      end
      default: begin
        phase_d = PH_IDLE;
      end
    endcase
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_q <= PH_IDLE;
    end else begin
      phase_q <= phase_d;
    end
  end

  // ---------------------------------------------------------------
  // Update decision
  // ---------------------------------------------------------------
  // A strobe rise pushes the word only once 16 falls were counted;
  // an earlier rise leaves the buffer and outputs untouched
  wire frame_full = (phase_q == PH_FULL) | (phase_q == PH_CHAIN);
  reg  push_q;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      push_q <= 1'b0;
    end else begin
      push_q <= sync_rise & frame_full;
    end
  end

  // ---------------------------------------------------------------
  // Chain output: the bit shifted out of the top, only past 16 clocks
  // ---------------------------------------------------------------
  wire chain_on = framed & (phase_q == PH_CHAIN);

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sdout_o    <= 1'b0;
      sdout_oe_o <= 1'b0;
    end else begin
      sdout_oe_o <= chain_on;
      sdout_o    <= chain_on & out_bit_q;
    end
  end

  // ---------------------------------------------------------------
  // Word buffer toward the converter
  // ---------------------------------------------------------------
  // The buffer pops on exactly the condition on which the output
  // stage loads, otherwise a word would be repeated
  wire             buf_ready;
  wire             buf_valid;
  wire [WIDTH-1:0] buf_data;
  wire             stage_free = ~word_valid_o | word_ready_i;
  wire             take       = buf_valid & stage_free;

  sfi_buf2 #(
    .WIDTH (WIDTH)
  ) u_buf (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (push_q),
    .in_ready_o  (buf_ready),
    .in_data_i   (shift_q),
    .out_valid_o (buf_valid),
    .out_ready_i (stage_free),
    .out_data_o  (buf_data)
  );

  // ---------------------------------------------------------------
  // Registered output stage
  // ---------------------------------------------------------------
  // Takes a word when empty or being drained; a push into a full
  // buffer is dropped and flagged until reset
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      word_o       <= `SFI_WORD_RST;
      word_valid_o <= 1'b0;
      overflow_o   <= 1'b0;
    end else begin
      if (take) begin
        word_o       <= buf_data;
        word_valid_o <= 1'b1;
      end else if (word_ready_i) begin
        word_valid_o <= 1'b0;
      end
      if (push_q && !buf_ready) begin
        overflow_o <= 1'b1;
      end
    end
  end
endmodule // sfi_frame_rx

// ### sfi_chk_checker.sv
// Checker for the serial frame input block
`timescale 1ns/1ps
module sfi_chk (
  input wire        clk_i,
  input wire        rst_n_i,
  input wire        sync_n_i,
  input wire        word_ready_i,
  input wire        sdout_o,
  input wire        sdout_oe_o,
  input wire        word_valid_o,
  input wire        overflow_o,
  input wire [15:0] word_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_word_held: assert property (word_valid_o && !word_ready_i |=> word_valid_o && $stable(word_o))
    else $error("word lost before accept");
  a_chain_quiet: assert property (!sdout_oe_o |-> !sdout_o)
    else $error("chain data without enable");
  a_chain_stop: assert property ($rose(sync_n_i) |-> ##[1:8] !sdout_oe_o)
    else $error("chain still driven after frame");
  a_chain_late: assert property ($fell(sync_n_i) |-> !sdout_oe_o [*8])
    else $error("chain driven at frame start");
  a_ovf_sticky: assert property (overflow_o |=> overflow_o)
    else $error("overflow flag cleared");
endmodule // sfi_chk
bind sfi_frame_rx sfi_chk u_chk (
  .clk_i        (clk_i),
  .rst_n_i      (rst_n_i),
  .sync_n_i     (sync_n_i),
  .word_ready_i (word_ready_i),
  .sdout_o      (sdout_o),
  .sdout_oe_o   (sdout_oe_o),
  .word_valid_o (word_valid_o),
  .overflow_o   (overflow_o),
  .word_o       (word_o)
);

// ### sfi_host.sv
// Host model driving the three-wire frame input
`timescale 1ns/1ps
module sfi_host (
  output reg sclk_o   = 1'b1,
  output reg sync_n_o = 1'b1,
  output reg sdin_o   = 1'b0
);
  // Sends n bits MSB first; the clock stands still between frames
  task frame(input integer n, input [31:0] d);
    integer i;
    begin
      sync_n_o = 1'b0;
      for (i = n - 1; i >= 0; i = i - 1) begin
        sdin_o = d[i];
        #80 sclk_o = 1'b0;
        #80 sclk_o = 1'b1;
      end
      #80 sync_n_o = 1'b1;
      sdin_o = ~sdin_o;
      #200;
    end
  endtask
endmodule // sfi_host

// ### tb_top.sv
// Testbench for the serial frame input block
`timescale 1ns/1ps
module tb_top;
  reg         clk_i = 0, rst_n_i = 0, word_ready_i = 0;
  wire        sclk_i, sync_n_i, sdin_i, sdout_o, sdout_oe_o, word_valid_o, overflow_o;
  wire [15:0] word_o;
  integer     fails = 0, compares = 0, oe_seen = 0, o;
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) oe_seen <= oe_seen + sdout_oe_o;
  // Next device in the chain: takes the chain output while it is driven
  reg  [3:0]  chain_q = 4'h0;
  always @(posedge sclk_i) if (sdout_oe_o) chain_q <= {chain_q[2:0], sdout_o};
  sfi_host u_sfi_host (.sclk_o(sclk_i), .sync_n_o(sync_n_i), .sdin_o(sdin_i));
  sfi_frame_rx u_sfi_frame_rx (.clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i), .sync_n_i(sync_n_i),
    .sdin_i(sdin_i), .sdout_o(sdout_o), .sdout_oe_o(sdout_oe_o), .word_o(word_o),
    .word_valid_o(word_valid_o), .word_ready_i(word_ready_i), .overflow_o(overflow_o));
  task end_of_test;
    begin
      if (fails == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  // Waits for a word, compares it and accepts it
  task pop(input [15:0] exp);
    integer n;
    begin
      n = 0;
      while (word_valid_o !== 1'b1 && n < 200) begin
        @(negedge clk_i);
        n = n + 1;
      end
      if (word_valid_o !== 1'b1) begin
        chk(16'h0001, 16'h0000);
        disable scenarios;
      end
      chk(word_o, exp);
      @(negedge clk_i) word_ready_i = 1'b1;
      @(negedge clk_i) word_ready_i = 1'b0;
    end
  endtask
  task t_abort;
    begin
      o = oe_seen;
      u_sfi_host.frame(14, 32'h3fff);
      u_sfi_host.frame(15, 32'h7fff);
      chk(word_valid_o, 16'h0000);
      u_sfi_host.frame(16, 32'ha5c3);
      chk(oe_seen == o, 16'h0001);
      pop(16'ha5c3);
    end
  endtask
  task t_chain;
    begin
      o = oe_seen;
      u_sfi_host.frame(20, 32'h5a5a5);
      chk(oe_seen > o, 16'h0001);
      chk({12'h000, chain_q}, 16'h0005);
      pop(16'ha5a5);
    end
  endtask
  task t_stall;
    begin
      u_sfi_host.frame(16, 32'h1111);
      u_sfi_host.frame(16, 32'h2222);
      u_sfi_host.frame(16, 32'h3333);
      u_sfi_host.frame(16, 32'h4444);
      chk(overflow_o, 16'h0001);
      pop(16'h1111);
      pop(16'h2222);
      pop(16'h3333);
      chk(word_valid_o, 16'h0000);
    end
  endtask
  initial begin
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    begin : scenarios
      t_abort;
      t_chain;
      t_stall;
    end
    end_of_test;
  end
endmodule // tb_top
